// [pkg/atw_defines.vh]
// Register offsets, field positions and timing counts for the converter control block
`ifndef ATW_DEFINES_VH
`define ATW_DEFINES_VH

`define ATW_OFF_CTRL     8'h00
`define ATW_OFF_RESULT   8'h04
`define ATW_OFF_LOWER    8'h08
`define ATW_OFF_UPPER    8'h0c
`define ATW_OFF_STATUS   8'h10
`define ATW_OFF_MASK     8'h14
`define ATW_OFF_CONFIG   8'h18

// Control register fields
`define ATW_CTL_EN       7
`define ATW_CTL_LPTRACK  6
`define ATW_CTL_DONE     5
`define ATW_CTL_BUSY     4
`define ATW_CTL_MODE_HI  3
`define ATW_CTL_MODE_LO  1
`define ATW_CTL_WIN      0

// Config register fields
`define ATW_CFG_DIFF     0
`define ATW_CFG_DIVLO    8
`define ATW_CFG_DIVHI    15

// Status / mask bits
`define ATW_ST_DONE      0
`define ATW_ST_WIN       1

// Start-mode codes
`define ATW_MODE_SW      3'h0
`define ATW_MODE_T3      3'h1
`define ATW_MODE_EXT     3'h2
`define ATW_MODE_T2      3'h3

// Phase lengths in converter clocks, and the reset value of the converter clock divider
`define ATW_TRACK_CLKS   4'h3
`define ATW_CONV_CLKS    4'h8
`define ATW_DIV_RESET    8'h07

`endif

// [core/atw_adc_track_window.v]
// Secondary converter start/tracking control with window detector and APB registers
//   Function
//   (R01) Mode 000 or 1xx: busy write of one starts three-clock tracking, then conversion.
//   (R02) Mode 011: timer 2 overflow starts three-clock tracking, then conversion.
//   (R03) Mode 010: track while external start is low, convert on its rising edge.
//   (R04) Mode 001: timer 3 overflow starts three-clock tracking, then conversion.
//   (R05) Own start pin used if routed; otherwise primary pin starts both converters.
//   (R06) Every result is compared against limits without CPU help.
//   (R07) Software loads lower bound into lower limit, upper bound into upper limit.
//   (R08) Window match sets a sticky flag; software clears it.
//   (R09) Inside or outside window is chosen only by limit ordering.
//   (R10) Single-ended mode compares results and limits as unsigned bytes.
//   (R11) Upper above lower: flag when result strictly between the limits.
//   (R12) Lower above upper: flag when result below upper or above lower.
//   (R13) Differential mode compares as two's-complement signed bytes.
//   (R14) Differential outside window uses signed comparison of both limits.
//   (R15) Conversion takes at least eight converter clocks after tracking ends.
`timescale 1ns/100ps
`include "atw_defines.vh"

module atw_adc_track_window (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        primaryBusyWrite,
  input  wire        timer2Overflow,
  input  wire        timer3Overflow,
  input  wire        extStartSecondary,
  input  wire        extStartPrimary,
  input  wire        extStartSecondaryRouted,
  input  wire [7:0]  sampleData,
  output reg         sampleHold,
  output reg         convBusy,
  output reg  [7:0]  conversionResult,
  output reg         irq
);

  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_TRACK = 4'b0010;
  localparam [3:0] ST_CONV  = 4'b0100;
  localparam [3:0] ST_EXT   = 4'b1000;

  reg  [3:0] state;
  reg  [3:0] phaseCnt;
  reg  [7:0] divCnt;
  reg  [7:0] clkDiv;
  reg        enable;
  reg        lowPowerTrack;
  reg  [2:0] startMode;
  reg        diffMode;
  reg  [7:0] lowerLimit;
  reg  [7:0] upperLimit;
  reg  [1:0] status;
  reg  [1:0] mask;
  reg        extPrev;
  reg  [3:0] next_state;
  reg  [31:0] next_prdata;

  wire       apbAccess = psel & penable & ~pready;
  wire       apbWrite  = apbAccess & pwrite;
  wire       convTick  = (divCnt == 8'h00);
  wire       extPin    = extStartSecondaryRouted ? extStartSecondary : extStartPrimary; // R05
  wire       extRise   = extPin & ~extPrev;
  wire       ctrlWrite = apbWrite & (paddr == `ATW_OFF_CTRL);
  // A busy write uses the enable and mode carried in the same word
  wire       busyWrite = ctrlWrite & pwdata[`ATW_CTL_BUSY] & pwdata[`ATW_CTL_EN] &
                         (pwdata[`ATW_CTL_MODE_HI:`ATW_CTL_MODE_LO] == `ATW_MODE_SW); // R01

  // Any access outside the map is refused with an error
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `ATW_OFF_CTRL)   | (addr == `ATW_OFF_RESULT) |
               (addr == `ATW_OFF_LOWER)  | (addr == `ATW_OFF_UPPER)  |
               (addr == `ATW_OFF_STATUS) | (addr == `ATW_OFF_MASK)   |
               (addr == `ATW_OFF_CONFIG);
    end
  endfunction

  // Returns a less than b, signed or unsigned
  function lessThan;
    input [7:0] a;
    input [7:0] b;
    input       signedCmp;
    begin
      if (signedCmp)
        lessThan = $signed(a) < $signed(b); // R13 R14
      else
        lessThan = a < b; // R10
    end
  endfunction

  // Window match decided from the limit ordering alone
  function windowHit;
    input [7:0] res;
    input [7:0] lo;
    input [7:0] hi;
    input       signedCmp;
    reg         aboveLo;
    reg         belowHi;
    begin
      aboveLo = lessThan(lo, res, signedCmp);
      belowHi = lessThan(res, hi, signedCmp);
      if (lessThan(lo, hi, signedCmp))
        windowHit = aboveLo & belowHi; // R09 R11
      else
        windowHit = aboveLo | belowHi; // R09 R12
    end
  endfunction

  // Last tick of a phase of the given length in converter clocks
  function phaseEnd;
    input       tick;
    input [3:0] count;
    input [3:0] length;
    begin
      phaseEnd = tick & (count == length - 4'h1);
    end
  endfunction

  // A start trigger for the current mode, seen only while idle
  reg trigger;
  always @* begin
    trigger = 1'b0;
    if (startMode[2])
      trigger = primaryBusyWrite; // R01
    else begin
      case (startMode)
        `ATW_MODE_SW:  trigger = 1'b0;
        `ATW_MODE_T3:  trigger = timer3Overflow; // R04
        `ATW_MODE_T2:  trigger = timer2Overflow; // R02
        `ATW_MODE_EXT: trigger = lowPowerTrack ? 1'b0 : extRise;
        default:       trigger = 1'b0;
      endcase
    end
  end

  wire extMode = lowPowerTrack & (startMode == `ATW_MODE_EXT);
  // Trigger events are pulses; they are latched so a slow converter clock does not lose them
  reg pendingStart;
  reg pendingExt;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enable & extMode & ~extPin)
          next_state = ST_EXT; // R03
        else if (enable & convTick & pendingStart)
          next_state = lowPowerTrack ? ST_TRACK : ST_CONV;
      end
      ST_TRACK: begin
        if (phaseEnd(convTick, phaseCnt, `ATW_TRACK_CLKS))
          next_state = ST_CONV; // R01 R02 R04
      end
      ST_EXT: begin
        if (~extMode | ~enable)
          next_state = ST_IDLE;
        else if (pendingExt & convTick)
          next_state = ST_CONV; // R03
      end
      ST_CONV: begin
        if (phaseEnd(convTick, phaseCnt, `ATW_CONV_CLKS))
          next_state = ST_IDLE; // R15
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Converter clock divider; one tick every clkDiv + 1 system clocks
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= convTick ? clkDiv : divCnt - 8'h01;
    end
  end

  // The pin history resets to the idle level so no false edge follows reset
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state   <= ST_IDLE;
      extPrev <= 1'b1;
    end else begin
      state   <= next_state;
      extPrev <= extPin;
    end
  end

  // Phase counter restarts on every state change and counts converter ticks
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phaseCnt <= 4'h0;
    end else if (next_state != state) begin
      phaseCnt <= 4'h0;
    end else if (convTick) begin
      phaseCnt <= phaseCnt + 4'h1;
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pendingStart <= 1'b0;
    end else if (state != ST_IDLE) begin
      pendingStart <= 1'b0;
    end else if ((trigger & enable) | busyWrite) begin
      pendingStart <= 1'b1; // R01 R02 R04
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pendingExt <= 1'b0;
    end else if (state != ST_EXT) begin
      pendingExt <= 1'b0;
    end else if (extRise) begin
      pendingExt <= 1'b1; // R03
    end
  end

  wire convDone = (state == ST_CONV) & (next_state == ST_IDLE);
  wire winEvent = convDone & windowHit(sampleData, lowerLimit, upperLimit, diffMode); // R06

  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `ATW_OFF_CTRL: begin
        next_prdata[`ATW_CTL_EN]      = enable;
        next_prdata[`ATW_CTL_LPTRACK] = lowPowerTrack;
        next_prdata[`ATW_CTL_DONE]    = status[`ATW_ST_DONE];
        next_prdata[`ATW_CTL_BUSY]    = convBusy;
        next_prdata[`ATW_CTL_MODE_HI:`ATW_CTL_MODE_LO] = startMode;
        next_prdata[`ATW_CTL_WIN]     = status[`ATW_ST_WIN];
      end
      `ATW_OFF_RESULT: next_prdata[7:0] = conversionResult;
      `ATW_OFF_LOWER:  next_prdata[7:0] = lowerLimit;
      `ATW_OFF_UPPER:  next_prdata[7:0] = upperLimit;
      `ATW_OFF_STATUS: next_prdata[1:0] = status;
      `ATW_OFF_MASK:   next_prdata[1:0] = mask;
      `ATW_OFF_CONFIG: begin
        next_prdata[`ATW_CFG_DIFF]               = diffMode;
        next_prdata[`ATW_CFG_DIVHI:`ATW_CFG_DIVLO] = clkDiv;
      end
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Register write strobes, one per writable register of the map other than the control register
  wire       lowerWrite  = apbWrite & (paddr == `ATW_OFF_LOWER);
  wire       upperWrite  = apbWrite & (paddr == `ATW_OFF_UPPER);
  wire       statusWrite = apbWrite & (paddr == `ATW_OFF_STATUS);
  wire       maskWrite   = apbWrite & (paddr == `ATW_OFF_MASK);
  wire       configWrite = apbWrite & (paddr == `ATW_OFF_CONFIG);

  // Sticky flag: an event landing in the same cycle as its clear wins
  function stickyNext;
    input flag;
    input setEvent;
    input clearReq;
    begin
      stickyNext = setEvent | (flag & ~clearReq);
    end
  endfunction

  // Bus answer; each access completes in one wait cycle
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess & ~mapped(paddr);
      prdata  <= (apbAccess & ~pwrite) ? next_prdata : 32'h00000000;
    end
  end

  // Control word takes effect at the access edge
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      enable        <= 1'b0;
      lowPowerTrack <= 1'b0;
      startMode     <= 3'h0;
    end else if (ctrlWrite) begin
      enable        <= pwdata[`ATW_CTL_EN];
      lowPowerTrack <= pwdata[`ATW_CTL_LPTRACK];
      startMode     <= pwdata[`ATW_CTL_MODE_HI:`ATW_CTL_MODE_LO];
    end
  end

  // Limits are kept as written; their ordering alone picks inside or outside
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowerLimit <= 8'h00;
      upperLimit <= 8'h00;
    end else begin
      if (lowerWrite)
        lowerLimit <= pwdata[7:0]; // R07
      if (upperWrite)
        upperLimit <= pwdata[7:0]; // R07
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask     <= 2'b00;
      diffMode <= 1'b0;
      clkDiv   <= `ATW_DIV_RESET;
    end else begin
      if (maskWrite)
        mask <= pwdata[1:0];
      if (configWrite) begin
        diffMode <= pwdata[`ATW_CFG_DIFF];
        clkDiv   <= pwdata[`ATW_CFG_DIVHI:`ATW_CFG_DIVLO];
      end
    end
  end

  // Status flags stay set until software writes a one to them
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status <= 2'b00;
      irq    <= 1'b0;
    end else begin
      status[`ATW_ST_DONE] <= stickyNext(status[`ATW_ST_DONE], convDone,
                                         statusWrite & pwdata[`ATW_ST_DONE]);
      status[`ATW_ST_WIN]  <= stickyNext(status[`ATW_ST_WIN], winEvent, // R08
                                         statusWrite & pwdata[`ATW_ST_WIN]);
      irq <= |(mask & status);
    end
  end

  // Hold is high while tracking or converting; normal track mode tracks when idle
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      convBusy         <= 1'b0;
      sampleHold       <= 1'b0;
      conversionResult <= 8'h00;
    end else begin
      convBusy   <= (next_state == ST_CONV);
      sampleHold <= (next_state != ST_IDLE) | ~lowPowerTrack;
      if (convDone)
        conversionResult <= sampleData;
    end
  end

endmodule // atw_adc_track_window

// [sim/atw_monitor.sv]
// Port checker for the converter control block
`timescale 1ns/100ps
module atw_monitor (
  input wire        sys_clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sampleHold,
  input wire        convBusy,
  input wire [7:0]  conversionResult
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Busy length; the bound holds for divider values from the reset value 7 up to 30
  reg [7:0] busyCnt;
  always @(posedge sys_clk or negedge resetn)
    if (!resetn) busyCnt <= 8'h00;
    else busyCnt <= convBusy ? busyCnt + 8'h01 : 8'h00;
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_pls; pready |=> !pready; endproperty
  a_pls: assert property (p_pls) else $error("long pready");
  property p_why; $rose(pready) |-> $past(psel && penable); endproperty
  a_why: assert property (p_why) else $error("stray pready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("prdata not zero");
  property p_res; !$stable(conversionResult) |-> $fell(convBusy); endproperty
  a_res: assert property (p_res) else $error("result moved");
  property p_len; $fell(convBusy) |-> busyCnt >= 8'h40; endproperty
  a_len: assert property (p_len) else $error("short conversion");
  property p_hld; convBusy |-> sampleHold; endproperty
  a_hld: assert property (p_hld) else $error("hold low");
endmodule // atw_monitor
bind atw_adc_track_window atw_monitor mon_u (.sys_clk(sys_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleHold(sampleHold), .convBusy(convBusy), .conversionResult(conversionResult));

// [sim/atw_start_src.sv]
// Start sources: timer overflows, primary busy write, convert-start pins
`timescale 1ns/100ps
module atw_start_src (
  input  wire       sys_clk,
  input  wire       kick,
  input  wire [2:0] kickSel,
  output wire       timer2Overflow,
  output wire       timer3Overflow,
  output wire       primaryBusyWrite,
  output wire       extStartSecondary,
  output wire       extStartPrimary
);
  reg [5:0] lowCnt = 6'h00;
  reg       usePri = 1'b0;
  assign timer2Overflow = kick && kickSel == 3'h3;
  assign timer3Overflow = kick && kickSel == 3'h1;
  assign primaryBusyWrite = kick && kickSel == 3'h4;
  // Pins idle high; a low stretch ends in the rising edge that starts conversion
  assign extStartSecondary = !(lowCnt != 6'h00 && !usePri);
  assign extStartPrimary = !(lowCnt != 6'h00 && usePri);
  always @(posedge sys_clk) begin
    if (kick) usePri <= kickSel[2];
    lowCnt <= (kick && kickSel[1:0] == 2'h2) ? 6'h28 : lowCnt - {5'h0, lowCnt != 6'h00};
  end
endmodule // atw_start_src

// [sim/adc_track_start_window_detect_test.sv]
// Bench for the converter control block
`timescale 1ns/100ps
`include "atw_defines.vh"
module adc_track_start_window_detect_test;
  reg         sys_clk, resetn, psel, penable, pwrite, kick, routed, err;
  reg  [7:0]  paddr, smp;
  reg  [31:0] pwdata, rd;
  reg  [2:0]  sel;
  reg  [1:0]  maskV;
  wire [31:0] prdata;
  wire [7:0]  res;
  wire        pready, pslverr, t2, t3, pb, es, ep, hold, busy, irq;
  integer     n_mismatch, comparisons, k;
  atw_adc_track_window dut_u (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primaryBusyWrite(pb), .timer2Overflow(t2),
    .timer3Overflow(t3), .extStartSecondary(es), .extStartPrimary(ep),
    .extStartSecondaryRouted(routed), .sampleData(smp), .sampleHold(hold),
    .convBusy(busy), .conversionResult(res), .irq(irq));
  atw_start_src src_u (.sys_clk(sys_clk), .kick(kick), .kickSel(sel), .timer2Overflow(t2),
    .timer3Overflow(t3), .primaryBusyWrite(pb), .extStartSecondary(es),
    .extStartPrimary(ep));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input [32:0] seen, input [32:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      for (k = 0; k < 9 && pready !== 1'b1; k = k + 1)
        @(posedge sys_clk);
      if (pready !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR pready exp 1 seen 0");
        stop_test;
      end
      {err, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
      @(posedge sys_clk);
    end
  endtask
  task lim(input [7:0] lo, input [7:0] hi, input diff, input [1:0] m);
    begin
      maskV = m;
      apb(1'b1, `ATW_OFF_MASK, {30'h0, m});
      apb(1'b1, `ATW_OFF_LOWER, {24'h0, lo});
      apb(1'b1, `ATW_OFF_UPPER, {24'h0, hi});
      apb(1'b1, `ATW_OFF_CONFIG, {16'h0, `ATW_DIV_RESET, 7'h0, diff});
      apb(1'b0, `ATW_OFF_LOWER, 32'h0);
      check({err, rd}, {1'b0, 24'h0, lo}, "lower");
    end
  endtask
  task conv(input [7:0] ctl, input [2:0] s, input [7:0] v, input ok, input win);
    integer n;
    begin
      smp <= v;
      apb(1'b1, `ATW_OFF_CTRL, {24'h0, ctl});
      {kick, sel} <= {1'b1, s};
      @(posedge sys_clk);
      kick <= 1'b0;
      if (s[1:0] == 2'h2 && ok) begin
        repeat (24) @(posedge sys_clk);
        check({hold, busy}, 2'b10, "tracking");
      end
      rd = 32'h0;
      for (n = 0; n < 60 && rd[0] !== 1'b1; n = n + 1)
        apb(1'b0, `ATW_OFF_STATUS, 32'h0);
      check(rd[0], ok, "done");
      if (ok) begin
        check(rd[1], win, "window");
        check(irq, |(maskV & {win, 1'b1}), "irq");
        apb(1'b0, `ATW_OFF_RESULT, 32'h0);
        check(rd, {24'h0, v}, "result");
        check(res, v, "result pin");
        apb(1'b1, `ATW_OFF_STATUS, 32'h3);
        apb(1'b0, `ATW_OFF_STATUS, 32'h0);
        check({irq, rd[1:0]}, 3'h0, "cleared");
      end
    end
  endtask
  task t_reset;
    begin
      apb(1'b0, `ATW_OFF_CTRL, 32'h0);
      check(rd, 32'h0, "ctrl");
      apb(1'b0, 8'h1c, 32'h0);
      check({err, rd}, 33'h100000000, "unmapped");
    end
  endtask
  task t_single;
    begin
      lim(8'h10, 8'h20, 1'b0, 2'h2);
      conv(8'hd0, 3'h0, 8'h10, 1'b1, 1'b0);
      conv(8'hc2, 3'h1, 8'h11, 1'b1, 1'b1);
      conv(8'hc6, 3'h3, 8'h1f, 1'b1, 1'b1);
      conv(8'hc8, 3'h4, 8'h20, 1'b1, 1'b0);
      lim(8'h20, 8'h10, 1'b0, 2'h3);
      conv(8'hc4, 3'h2, 8'h0f, 1'b1, 1'b1);
      conv(8'hd0, 3'h0, 8'h10, 1'b1, 1'b0);
      conv(8'hd0, 3'h0, 8'hff, 1'b1, 1'b1);
    end
  endtask
  task t_diff;
    begin
      lim(8'hff, 8'h10, 1'b1, 2'h3);
      conv(8'hd0, 3'h0, 8'h00, 1'b1, 1'b1);
      conv(8'hd0, 3'h0, 8'hff, 1'b1, 1'b0);
      lim(8'h10, 8'hff, 1'b1, 2'h3);
      conv(8'hd0, 3'h0, 8'hfe, 1'b1, 1'b1);
      conv(8'hd0, 3'h0, 8'h10, 1'b1, 1'b0);
      conv(8'h90, 3'h0, 8'h11, 1'b1, 1'b1);
      conv(8'h84, 3'h2, 8'h05, 1'b1, 1'b0);
    end
  endtask
  task t_route;
    begin
      routed <= 1'b0;
      conv(8'hc4, 3'h2, 8'h33, 1'b0, 1'b0);
      conv(8'hc4, 3'h6, 8'h44, 1'b1, 1'b1);
    end
  endtask
  initial begin
    {resetn, psel, penable, pwrite, kick, routed} = 6'h01;
    {paddr, pwdata, smp, sel, maskV} = 53'h0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_single;
    t_diff;
    t_route;
    stop_test;
  end
endmodule // adc_track_start_window_detect_test
